// >>> logic/button_events_defines.vh
// Constants for the power and sleep key event block
`ifndef BUTTON_EVENTS_DEFINES_VH
`define BUTTON_EVENTS_DEFINES_VH

// ==========================================
// I/O map of the control-method key registers
`define POWER_KEY_EVENT_STATUS_ADDR 16'h0200
`define SLEEP_KEY_EVENT_STATUS_ADDR 16'h0201
`define KEY_REQUEST_BIT             0
`define KEY_WAKE_BIT                1
`define KEY_STATUS_RESET            2'h0
`define IO_READ_UNMAPPED            8'h00

// ==========================================
// System state codes
`define STATE_WORKING  2'h0
`define STATE_SLEEPING 2'h1
`define STATE_SOFT_OFF 2'h2

// ==========================================
// Key model codes
`define KEY_MODEL_NONE   2'h0
`define KEY_MODEL_FIXED  2'h1
`define KEY_MODEL_METHOD 2'h2

// ==========================================
// Timing
`define CLK_PERIOD_NS   32'd4
`define CYCLES_PER_MS   (32'd1000000 / `CLK_PERIOD_NS)
`define DEBOUNCE_MS     32'd10
`define DEBOUNCE_CYCLES (`DEBOUNCE_MS * `CYCLES_PER_MS)
`define OVERRIDE_MS     32'd4000
`define OVERRIDE_CYCLES (`OVERRIDE_MS * `CYCLES_PER_MS)

`endif

// >>> logic/power_sleep_button_events.v
// Power and sleep key debounce, status flags, wake and override logic
//
// Summary of operation
// RQ1 - Power held over four seconds forces soft-off
// RQ2 - Override clears power key status flag
// RQ3 - Sleep absent flag low only for fixed
// RQ4 - Sleep press sets sticky status until cleared
// RQ5 - Sleep interrupt when enabled and working
// RQ6 - Sleep key debounced, flag set on edge
// RQ7 - Software clears sleep flag on interrupt
// RQ8 - Sleep press while sleeping sets, may wake
// RQ9 - Power method register byte at 0x200
// RQ10 - Method status bits clear on writing one
// RQ11 - Power request drives general event zero
// RQ12 - Power handler clears, then notifies software
// RQ13 - Sleep method register byte at 0x201
// RQ14 - Sleep handler clears, then notifies software
// RQ15 - Sleep key never requests soft-off
// RQ16 - Power press sets flag; interrupt when enabled
// RQ17 - Power press while asleep/off wakes always
// RQ18 - Override delivered as dedicated off signal
// RQ19 - Zero writes keep bits; set beats clear
// RQ20 - Hold timer restarts on release, fires once
`include "button_events_defines.vh"
`default_nettype none

module power_sleep_button_events #(
   parameter [31:0] DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES,
   parameter [31:0] OVERRIDE_CYCLES = `OVERRIDE_CYCLES
) (
   // Clock and reset
   input  wire        clock,
   input  wire        rstn,
   // Key pins, low while pressed
   input  wire        powerKeyPinN,
   input  wire        sleepKeyPinN,
   // Platform configuration and state
   input  wire [1:0]  powerKeyModel,
   input  wire [1:0]  sleepKeyModel,
   input  wire [1:0]  systemState,
   // Fixed event controls
   input  wire        powerKeyEventEnable,
   input  wire        sleepKeyEventEnable,
   input  wire        sleepSequenceEnable,
   input  wire        powerKeyStatusClear,
   input  wire        sleepKeyStatusClear,
   // Byte I/O port
   input  wire [15:0] ioAddr,
   input  wire [7:0]  ioWrData,
   input  wire        ioWr,
   input  wire        ioRd,
   output reg  [7:0]  ioRdData,
   // Status and events
   output reg         powerKeyStatusFlag,
   output reg         sleepKeyStatusFlag,
   output reg         powerKeyAbsentFlag,
   output reg         sleepKeyAbsentFlag,
   output reg         systemControlInterrupt,
   output reg         wakeRequest,
   output reg         sleepTransitionRequest,
   output reg         powerKeyOverride,
   output reg         generalEventStatusZero,
   output reg         generalEventStatusOne
);

   // ==========================================
   // Per-key synchroniser and debounce
   wire [1:0] pinN = {sleepKeyPinN, powerKeyPinN};
   wire [1:0] keyDown;
   wire [1:0] pressEdge;

   genvar k;
   generate
      for (k = 0; k < 2; k = k + 1) begin : keyLane
         reg [2:0]  sync;
         reg [31:0] stableCount;
         reg        debounced;
         reg        edgePulse;
         wire       agreed = (sync[1] == sync[2]);
         wire       level  = ~sync[2];
         always @(posedge clock or negedge rstn) begin
            if (!rstn) begin
               sync        <= 3'h7;
               stableCount <= 32'h0;
               debounced   <= 1'b0;
               edgePulse   <= 1'b0;
            end else begin
               sync      <= {sync[1:0], pinN[k]};
               edgePulse <= 1'b0;
               if (!agreed || level == debounced) begin
                  stableCount <= 32'h0;
               end else if (stableCount >= DEBOUNCE_CYCLES - 32'h1) begin
                  stableCount <= 32'h0;
                  debounced   <= level;
                  edgePulse   <= level; // [RQ6]
               end else begin
                  stableCount <= stableCount + 32'h1;
               end
            end
         end
         assign keyDown[k]   = debounced;
         assign pressEdge[k] = edgePulse;
      end
   endgenerate

   wire powerDown  = keyDown[0];
   wire powerPress = pressEdge[0];
   wire sleepPress = pressEdge[1];

   wire working  = (systemState == `STATE_WORKING);
   wire sleeping = (systemState == `STATE_SLEEPING);
   wire softOff  = (systemState == `STATE_SOFT_OFF);

   // ==========================================
   // Override hold timer
   reg [31:0] holdCount;
   reg        holdFired;
   wire       overrideHit = powerDown && working && !holdFired
                            && (holdCount >= OVERRIDE_CYCLES);

   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         holdCount        <= 32'h0;
         holdFired        <= 1'b0;
         powerKeyOverride <= 1'b0;
      end else begin
         powerKeyOverride <= overrideHit; // [RQ18]
         if (!powerDown || !working) begin
            holdCount <= 32'h0; // [RQ20]
            holdFired <= 1'b0;
         end else if (overrideHit) begin
            holdFired <= 1'b1; // [RQ1] [RQ20]
         end else if (!holdFired) begin
            holdCount <= holdCount + 32'h1;
         end
      end
   end

   // ==========================================
   // Fixed status flags
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         powerKeyStatusFlag <= 1'b0;
         sleepKeyStatusFlag <= 1'b0;
      end else begin
         if (powerPress)
            powerKeyStatusFlag <= 1'b1; // [RQ16] [RQ17] [RQ19]
         else if (overrideHit)
            powerKeyStatusFlag <= 1'b0; // [RQ2]
         else if (powerKeyStatusClear)
            powerKeyStatusFlag <= 1'b0;
         if (sleepPress)
            sleepKeyStatusFlag <= 1'b1; // [RQ4] [RQ8] [RQ19]
         else if (sleepKeyStatusClear)
            sleepKeyStatusFlag <= 1'b0; // [RQ7]
      end
   end

   // ==========================================
   // Interrupt, wake and transition requests
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         systemControlInterrupt <= 1'b0;
         wakeRequest            <= 1'b0;
         sleepTransitionRequest <= 1'b0;
      end else begin
         systemControlInterrupt <= working && // [RQ5] [RQ16]
            ((powerKeyStatusFlag && powerKeyEventEnable) ||
             (sleepKeyStatusFlag && sleepKeyEventEnable));
         wakeRequest <= (powerPress && (sleeping || softOff)) // [RQ17]
            || (sleepPress && sleeping && sleepSequenceEnable); // [RQ8]
         sleepTransitionRequest <= sleepPress && working; // [RQ15]
      end
   end

   // ==========================================
   // Key presence flags
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         powerKeyAbsentFlag <= 1'b1;
         sleepKeyAbsentFlag <= 1'b1;
      end else begin
         powerKeyAbsentFlag <= (powerKeyModel != `KEY_MODEL_FIXED);
         sleepKeyAbsentFlag <= (sleepKeyModel != `KEY_MODEL_FIXED); // [RQ3]
      end
   end

   // ==========================================
   // Control-method status registers
   reg  [1:0] powerMethodStatus;
   reg  [1:0] sleepMethodStatus;
   reg  [1:0] next_powerMethodStatus;
   reg  [1:0] next_sleepMethodStatus;
   wire       powerMethod = (powerKeyModel == `KEY_MODEL_METHOD);
   wire       sleepMethod = (sleepKeyModel == `KEY_MODEL_METHOD);
   wire       hitPower = (ioAddr == `POWER_KEY_EVENT_STATUS_ADDR); // [RQ9]
   wire       hitSleep = (ioAddr == `SLEEP_KEY_EVENT_STATUS_ADDR); // [RQ13]
   wire [1:0] powerSet;
   wire [1:0] sleepSet;
   wire [1:0] powerClr = (ioWr && hitPower) ? ioWrData[1:0] : 2'h0;
   wire [1:0] sleepClr = (ioWr && hitSleep) ? ioWrData[1:0] : 2'h0;

   assign powerSet[`KEY_REQUEST_BIT] = powerMethod && powerPress && working;
   assign powerSet[`KEY_WAKE_BIT]    = powerMethod && powerPress && !working;
   assign sleepSet[`KEY_REQUEST_BIT] = sleepMethod && sleepPress && working;
   assign sleepSet[`KEY_WAKE_BIT]    = sleepMethod && sleepPress && sleeping;

   always @* begin
      next_powerMethodStatus = (powerMethodStatus & ~powerClr) | powerSet; // [RQ10] [RQ19]
      next_sleepMethodStatus = (sleepMethodStatus & ~sleepClr) | sleepSet; // [RQ10] [RQ19]
   end

   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         powerMethodStatus      <= `KEY_STATUS_RESET;
         sleepMethodStatus      <= `KEY_STATUS_RESET;
         generalEventStatusZero <= 1'b0;
         generalEventStatusOne  <= 1'b0;
      end else begin
         powerMethodStatus      <= next_powerMethodStatus;
         sleepMethodStatus      <= next_sleepMethodStatus;
         generalEventStatusZero <= next_powerMethodStatus[`KEY_REQUEST_BIT]; // [RQ11]
         generalEventStatusOne  <= next_sleepMethodStatus[`KEY_REQUEST_BIT];
      end
   end

   // ==========================================
   // Read port
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ioRdData <= `IO_READ_UNMAPPED;
      end else if (ioRd) begin
         if (hitPower)
            ioRdData <= {6'h00, powerMethodStatus}; // [RQ9]
         else if (hitSleep)
            ioRdData <= {6'h00, sleepMethodStatus}; // [RQ13]
         else
            ioRdData <= `IO_READ_UNMAPPED;
      end
   end

endmodule // power_sleep_button_events

`default_nettype wire

// >>> testbench/push_key_model.sv
// Push-key model with contact bounce and pull-up
`default_nettype none
module push_key_model (
   input  wire logic clock,
   input  wire logic hold,
   output logic      pinN
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] chat = 2'h0;
   logic       last = 1'b0;
   // Contacts chatter for three cycles after closing
   always @(posedge clock) begin
      last <= hold;
      chat <= (hold && !last) ? 2'h3 : chat - {1'b0, chat != 2'h0};
   end
   // Pull-up holds the pin high while released
   assign pinN = !(hold && !chat[0]);
endmodule // push_key_model
`default_nettype wire

// >>> testbench/power_sleep_button_events_chk.sv
// Assertions for the power and sleep key event block
`include "button_events_defines.vh"
`default_nettype none
module power_sleep_button_events_chk (
   // Inputs
   input wire logic       clock, rstn, sleepKeyPinN, powerKeyEventEnable, sleepKeyEventEnable,
   input wire logic       powerKeyStatusClear, sleepKeyStatusClear,
   input wire logic [1:0] sleepKeyModel, systemState,
   // Outputs
   input wire logic       powerKeyStatusFlag, sleepKeyStatusFlag, sleepKeyAbsentFlag,
   input wire logic       systemControlInterrupt, wakeRequest, sleepTransitionRequest,
   input wire logic       powerKeyOverride
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   // ==========
   // Checks
   a_sci_level: assert property (systemControlInterrupt == $past(systemState ==
      `STATE_WORKING && (powerKeyStatusFlag && powerKeyEventEnable
      || sleepKeyStatusFlag && sleepKeyEventEnable))) else $error("bad interrupt");
   a_override_clears: assert property (powerKeyOverride |-> !powerKeyStatusFlag)
      else $error("override kept flag");
   a_override_working: assert property (powerKeyOverride |-> $past(systemState) == 0)
      else $error("override not working");
   a_override_pulse: assert property (powerKeyOverride |=> !powerKeyOverride)
      else $error("override too long");
   a_absent_model: assert property ($past(rstn) |-> sleepKeyAbsentFlag ==
      ($past(sleepKeyModel) != `KEY_MODEL_FIXED)) else $error("bad absent flag");
   a_wake_asleep: assert property (wakeRequest |-> $past(systemState) != 0)
      else $error("wake while working");
   a_sleep_request: assert property (sleepTransitionRequest |->
      $past(systemState) == 0 && !powerKeyOverride) else $error("bad sleep request");
   a_sleep_sticky: assert property ($fell(sleepKeyStatusFlag) |->
      $past(sleepKeyStatusClear)) else $error("sleep flag lost");
   a_power_sticky: assert property ($fell(powerKeyStatusFlag) |->
      $past(powerKeyStatusClear) || powerKeyOverride) else $error("power flag lost");
   a_sleep_edge: assert property ($rose(sleepKeyStatusFlag) |-> !$past(sleepKeyPinN, 5))
      else $error("flag without press");
   c_override: cover property (powerKeyOverride);
   c_wake: cover property (wakeRequest);
   c_sleep: cover property (sleepTransitionRequest);
endmodule // power_sleep_button_events_chk
bind power_sleep_button_events power_sleep_button_events_chk i_chk (.clock, .rstn,
   .sleepKeyPinN, .powerKeyEventEnable, .sleepKeyEventEnable, .powerKeyStatusClear,
   .sleepKeyStatusClear, .sleepKeyModel, .systemState, .powerKeyStatusFlag, .sleepKeyStatusFlag,
   .sleepKeyAbsentFlag, .systemControlInterrupt, .wakeRequest, .sleepTransitionRequest,
   .powerKeyOverride);
`default_nettype wire

// >>> testbench/power_sleep_button_events_tb.sv
// Self-checking bench for the power and sleep key event block
`include "button_events_defines.vh"
`default_nettype none
module power_sleep_button_events_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ==========
   // Signals
   logic clock = 0, rstn = 0, holdP = 0, holdS = 0, powerKeyEventEnable = 0, ioWr = 0, ioRd = 0;
   logic sleepKeyEventEnable = 0, sleepSequenceEnable = 0, powerKeyStatusClear = 0;
   logic sleepKeyStatusClear = 0;
   logic [1:0] powerKeyModel = 0, sleepKeyModel = 0, systemState = 0;
   logic [15:0] ioAddr = 0;
   logic [7:0] ioWrData = 0, rd;
   wire logic [7:0] ioRdData;
   wire logic powerKeyPinN, sleepKeyPinN, powerKeyStatusFlag, sleepKeyStatusFlag, wakeRequest;
   wire logic powerKeyAbsentFlag, sleepKeyAbsentFlag, systemControlInterrupt, powerKeyOverride;
   wire logic sleepTransitionRequest, generalEventStatusZero, generalEventStatusOne;
   int num_errors = 0, checks = 0, cycles = 0, nWake = 0, nReq = 0, nOvr = 0;
   int seed = 32'h063C;
   power_sleep_button_events #(.DEBOUNCE_CYCLES(32'h4), .OVERRIDE_CYCLES(32'h32))
      i_power_sleep_button_events (
      .clock, .rstn, .powerKeyPinN, .sleepKeyPinN, .powerKeyModel, .sleepKeyModel, .systemState,
      .powerKeyEventEnable, .sleepKeyEventEnable, .sleepSequenceEnable, .powerKeyStatusClear,
      .sleepKeyStatusClear, .ioAddr, .ioWrData, .ioWr, .ioRd, .ioRdData, .powerKeyStatusFlag,
      .sleepKeyStatusFlag, .powerKeyAbsentFlag, .sleepKeyAbsentFlag, .systemControlInterrupt,
      .wakeRequest, .sleepTransitionRequest, .powerKeyOverride, .generalEventStatusZero,
      .generalEventStatusOne);
   push_key_model i_power_key (.clock(clock), .hold(holdP), .pinN(powerKeyPinN));
   push_key_model i_sleep_key (.clock(clock), .hold(holdS), .pinN(sleepKeyPinN));
   initial forever #2 clock = !clock;
   // ==========
   // Pulse counters and timeout
   always @(posedge clock) begin
      cycles <= cycles + 1;
      nWake <= nWake + wakeRequest;
      nReq <= nReq + sleepTransitionRequest;
      nOvr <= nOvr + powerKeyOverride;
      if (cycles == 3000) begin
         num_errors++;
         finish_test();
      end
   end
   // ==========
   // Tasks
   task check(string what, logic [7:0] seen, logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task tick(int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task io(logic wr, logic [15:0] a, logic [7:0] d);
      {ioWr, ioRd, ioAddr, ioWrData} = {wr, !wr, a, d};
      tick(1);
      rd = ioRdData;
      {ioWr, ioRd} = 2'h0;
      tick(1);
   endtask
   task press(logic pwr, int n);
      {holdP, holdS} = {pwr, !pwr};
      tick(n);
      {holdP, holdS} = 2'h0;
      tick(14);
   endtask
   function automatic logic expSci(logic en);
      return systemState == `STATE_WORKING && en;
   endfunction
   task finish_test();
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // ==========
   // Scenarios
   initial begin
      tick(5);
      rstn = 1;
      for (int m = 0; m < 3; m++) begin
         {powerKeyModel, sleepKeyModel} = {2{m[1:0]}};
         tick(2);
         check("absent", sleepKeyAbsentFlag, m != `KEY_MODEL_FIXED);
         check("pabsent", powerKeyAbsentFlag, m != `KEY_MODEL_FIXED);
      end
      powerKeyEventEnable = 1'($random(seed));
      sleepKeyEventEnable = 1'($random(seed));
      press(1, 16);
      check("sci", systemControlInterrupt, expSci(powerKeyEventEnable));
      io(0, `POWER_KEY_EVENT_STATUS_ADDR, 0);
      check("reg200", rd, 8'h01);
      check("gev0", generalEventStatusZero, 1);
      io(1, `POWER_KEY_EVENT_STATUS_ADDR, 8'hFE);
      check("gev0", generalEventStatusZero, 1);
      io(1, `POWER_KEY_EVENT_STATUS_ADDR, 8'h01);
      check("gev0", generalEventStatusZero, 0);
      powerKeyStatusClear = 1;
      tick(1);
      powerKeyStatusClear = 0;
      $display("power test done");
      press(0, 16);
      check("sci", systemControlInterrupt, expSci(sleepKeyEventEnable));
      check("sreq", nReq, 1);
      io(0, `SLEEP_KEY_EVENT_STATUS_ADDR, 0);
      check("reg201", rd, 8'h01);
      check("gev1", generalEventStatusOne, 1);
      io(1, `SLEEP_KEY_EVENT_STATUS_ADDR, 8'h03);
      check("gev1", generalEventStatusOne, 0);
      sleepKeyStatusClear = 1;
      tick(1);
      sleepKeyStatusClear = 0;
      repeat (4) press(0, {$random(seed)} % 3 + 1);
      check("glitch", sleepKeyStatusFlag, 0);
      $display("sleep test done");
      {systemState, sleepSequenceEnable} = {`STATE_SLEEPING, 1'b1};
      press(0, 16);
      check("wake", nWake, 1);
      check("sflag", sleepKeyStatusFlag, 1);
      check("sci", systemControlInterrupt, expSci(sleepKeyEventEnable));
      io(0, `SLEEP_KEY_EVENT_STATUS_ADDR, 0);
      check("reg201", rd, 8'h02);
      {systemState, powerKeyEventEnable} = {`STATE_SOFT_OFF, 1'b0};
      press(1, 16);
      check("wake", nWake, 2);
      check("pflag", powerKeyStatusFlag, 1);
      io(0, `POWER_KEY_EVENT_STATUS_ADDR, 0);
      check("reg200", rd, 8'h02);
      io(0, 16'h0202, 0);
      check("unmapped", rd, 8'h00);
      $display("wake test done");
      {systemState, powerKeyModel} = {`STATE_WORKING, `KEY_MODEL_FIXED};
      repeat (2) press(1, 40);
      check("ovr", nOvr, 0);
      check("gev0", generalEventStatusZero, 0);
      press(1, 130);
      check("ovr", nOvr, 1);
      check("pflag", powerKeyStatusFlag, 0);
      $display("override test done");
      finish_test();
   end
endmodule // power_sleep_button_events_tb
`default_nettype wire
